// ===== hdl/hcw_pkg.sv
// Constants, state codes and carrier types for the hopping code word transmitter.
// Assumes a single 200 MHz clock; all times below are turned into cycle counts here.
package hcw_pkg;
  // Clock and element timing
  localparam int CLK_NS = 5;
  localparam int TE_NS = 100_000;
  localparam int TE_CYCLES = TE_NS / CLK_NS;
  localparam int ENTRY_HOLD_NS = 9_000_000;
  localparam int ENTRY_HOLD_CYCLES = (ENTRY_HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int TWC_NS = 30_000_000;
  localparam int TWC_CYCLES = TWC_NS / CLK_NS;
  localparam int LED_HALF_NS = 500_000_000;
  localparam int LED_HALF_CYCLES = LED_HALF_NS / CLK_NS;

  // Frame shape in elements and bits
  localparam logic [6:0] PREAMBLE_SLOTS = 7'h17;
  localparam logic [6:0] HEADER_SLOTS = 7'h0A;
  localparam logic [6:0] GUARD_SLOTS = 7'h32;
  localparam logic [6:0] PWM_LAST_SLOT = 7'h02;
  localparam logic [6:0] MAN_LAST_SLOT = 7'h01;
  localparam logic [6:0] VLOW_IDX = 7'h40;
  localparam logic [6:0] LAST_IDX = 7'h42;
  localparam logic [8:0] MIN_WORDS = 9'h002;
  localparam logic [8:0] TIMEOUT_WORDS = 9'h100;

  // Programming port layout
  localparam logic [4:0] PROG_LAST_BIT = 5'h1F;
  localparam logic [7:0] VERIFY_LAST_BIT = 8'hBF;
  localparam logic [3:0] LAST_WORD = 4'hB;
  localparam logic [3:0] SYNC_WORD = 4'h6;
  localparam int PROG_WORDS = 12;

  typedef enum logic [9:0] {
    ST_IDLE = 10'h001,
    ST_PRE = 10'h002,
    ST_HDR = 10'h004,
    ST_DAT = 10'h008,
    ST_GRD = 10'h010,
    ST_OFF = 10'h020,
    ST_PSH = 10'h040,
    ST_PWR = 10'h080,
    ST_ACK = 10'h100,
    ST_VFY = 10'h200
  } hcw_state_t;

  // Static option straps
  typedef struct packed {
    logic long_guard_enable;
    logic timeout_enable;
    logic manchester_select;
    logic extended_serial_select;
    logic independent_counter_select;
    logic counter_wrap_flag;
    logic [1:0] user_bits;
  } hcw_cfg_t;
endpackage : hcw_pkg

// ===== hdl/hcw_sync.sv
// Two-stage synchroniser bank for pins entering the clock domain.
// Assumes inputs are asynchronous levels; only the second stage is visible.
`timescale 1ns/10ps
module hcw_sync #(
  parameter int W = 6
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  import hcw_pkg::*;

  generate
    if (W < 1)
    begin : g_chk
      $error("hcw_sync width must be positive");
    end
  endgenerate

  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      logic meta_reg;
      logic sync_reg;
      // First stage feeds only the second stage
      always_ff @(posedge clk)
      begin
        if (!nrst)
        begin
          meta_reg <= 1'b0;
          sync_reg <= 1'b0;
        end
        else
        begin
          meta_reg <= d[i];
          sync_reg <= meta_reg;
        end
      end
      assign q[i] = sync_reg;
    end
  endgenerate
endmodule : hcw_sync

// ===== hdl/hcw_cipher.sv
// Iterative block mixer turning the 32-bit plaintext into the hopping word.
// Assumes start is a one-cycle pulse; done stays high until the next start.
`timescale 1ns/10ps
module hcw_cipher #(
  parameter int ROUNDS = 64
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic start,
  input wire logic [31:0] plain,
  input wire logic [63:0] key,
  output logic [31:0] hop,
  output logic done
);
  import hcw_pkg::*;

  // Arbitrary nonlinear table, not tied to any existing product
  localparam logic [31:0] MIX_TABLE = 32'h6C9E_1B35;

  generate
    if (ROUNDS < 1 || ROUNDS > 127)
    begin : g_chk
      $error("hcw_cipher rounds out of range");
    end
  endgenerate

  logic [31:0] st_reg, st_next;
  logic [6:0] rnd_reg, rnd_next;
  logic done_reg, done_next;
  logic fb;

  // One round per cycle: rotate with keyed nonlinear feedback
  always_comb
  begin
    fb = st_reg[0] ^ st_reg[16] ^ key[rnd_reg[5:0]]
      ^ MIX_TABLE[{st_reg[31], st_reg[26], st_reg[20], st_reg[9], st_reg[1]}];
    st_next = st_reg;
    rnd_next = rnd_reg;
    done_next = done_reg;
    if (start)
    begin
      st_next = plain;
      rnd_next = 7'(ROUNDS);
      done_next = 1'b0;
    end
    else if (rnd_reg != 7'h00)
    begin
      st_next = {fb, st_reg[31:1]};
      rnd_next = rnd_reg - 7'h01;
      done_next = (rnd_reg == 7'h01);
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      st_reg <= 32'h0000_0000;
      rnd_reg <= 7'h00;
      done_reg <= 1'b0;
    end
    else
    begin
      st_reg <= st_next;
      rnd_reg <= rnd_next;
      done_reg <= done_next;
    end
  end

  assign hop = st_reg;
  assign done = done_reg;
endmodule : hcw_cipher

// ===== hdl/hcw_top.sv
// Hopping code word transmitter: framing, session control, indicator and programming port.
// Assumes option straps are static; button, supply flag and data pin inputs are asynchronous.
// Behaviour
// - Each word goes preamble, header, encrypted block, fixed block, then a guard gap.
// - Payload is 67 bits: 32 encrypted then 35 fixed.
// - Plaintext holds function, user, wrap, independent, 8 serial bits and 16-bit counter.
// - Fixed block holds 28-bit serial, function bits, low-battery flag and two CRC bits.
// - Extended serial sends all 32 serial bits, no function bits there.
// - Wake on a press, finish words, send two at least, sleep after release.
// - A held button keeps the words repeating.
// - A newly pressed button aborts the current word and restarts with new buttons.
// - Long guard sends only every second word.
// - Two-bit CRC over bits 0 to 64 from zero with the given update.
// - Low-battery flag sampled in the bit's last slot for CRC (the low phase with PWM coding), at bit start for sending.
// - With timeout enabled, a long continuous press stops transmission.
// - The low-battery flag rides in every word.
// - Indicator is low while data goes out and high in the guard.
// - With low supply the indicator toggles every LED_CYC cycles of sending, restarting each word, so with the 500 ms default it stays low.
// - Each accepted word triggers a fixed 30 ms write before the acknowledge.
// - Each word comes with its complement; a mismatch ends programming.
// - Readback allowed once, only right after programming.
// - Timeout forces data low and indicator off until all buttons are released.
// - Manchester select picks Manchester, else pulse width coding.
// - Without extended serial the top four serial bits become function bits.
`timescale 1ns/10ps
module hcw_top #(
  parameter int TE_CYC = hcw_pkg::TE_CYCLES,
  parameter int HOLD_CYC = hcw_pkg::ENTRY_HOLD_CYCLES,
  parameter int TWC_CYC = hcw_pkg::TWC_CYCLES,
  parameter int LED_CYC = hcw_pkg::LED_HALF_CYCLES
) (
  input wire logic clk,
  input wire logic nrst,
  input wire hcw_pkg::hcw_cfg_t cfg,
  input wire logic button_zero_in,
  input wire logic button_one_in,
  input wire logic button_two_in,
  input wire logic button_three_in,
  input wire logic vlow_in,
  input wire logic data_in,
  output logic data_out,
  output logic data_oe_n,
  output logic indicator_out_n
);
  import hcw_pkg::*;

  generate
    if (TE_CYC < 2 || HOLD_CYC < 1 || TWC_CYC < 1 || LED_CYC < 1)
    begin : g_chk
      $error("hcw_top timing parameters too small");
    end
  endgenerate

  logic [5:0] pin_s;
  logic [3:0] btns;
  logic vlow_s, data_s, any_btn, tick, pedge, pclk_s, tx_st, new_btn, launch, wr_en;
  logic hold_ok, cdone, cur_bit, crc_d;
  logic [6:0] last_slot;
  logic [31:0] enc_w, serial_w, fixed_w, sh;
  logic [63:0] payload, key_w;
  hcw_state_t st_reg, st_next;
  logic [31:0] te_reg, te_next, hold_reg, hold_next, pcnt_reg, pcnt_next;
  logic [6:0] slot_reg, slot_next, idx_reg, idx_next;
  logic [1:0] crc_reg, crc_next;
  logic [8:0] words_reg, words_next;
  logic [3:0] btn_reg, btn_next, widx_reg, widx_next;
  logic [15:0] sync_reg, sync_next;
  logic [31:0] psh_reg, psh_next, ptxt_reg, ptxt_next;
  logic [7:0] pbits_reg, pbits_next;
  logic vtx_reg, vtx_next, par_reg, par_next, mute_reg, mute_next, wrap_reg, wrap_next;
  logic vok_reg, vok_next, cst_reg, cst_next, pclk_reg;
  logic [15:0] mem_reg [PROG_WORDS];
  logic [15:0] mem_next [PROG_WORDS];

  hcw_sync #(.W(6)) u_sync (
    .clk(clk),
    .nrst(nrst),
    .d({button_three_in, button_two_in, button_one_in, button_zero_in, vlow_in, data_in}),
    .q(pin_s)
  );

  // Plaintext is latched at launch; the preamble gives the mixer ample time
  hcw_cipher #(.ROUNDS(64)) u_cipher (
    .clk(clk),
    .nrst(nrst),
    .start(cst_reg),
    .plain(ptxt_reg),
    .key(key_w),
    .hop(enc_w),
    .done(cdone)
  );

  // Decoded views of inputs and stored words
  assign btns = pin_s[5:2];
  assign vlow_s = pin_s[1];
  assign data_s = pin_s[0];
  assign pclk_s = pin_s[5] | pin_s[4];
  assign any_btn = |btns;
  assign pedge = pclk_s & ~pclk_reg;
  assign tick = (te_reg == 32'(TE_CYC - 1));
  assign hold_ok = (hold_reg == 32'(HOLD_CYC));
  assign tx_st = (st_reg == ST_PRE) || (st_reg == ST_HDR) || (st_reg == ST_DAT);
  assign new_btn = |(btns & ~btn_reg);
  assign last_slot = cfg.manchester_select ? MAN_LAST_SLOT : PWM_LAST_SLOT;
  assign key_w = {mem_reg[3], mem_reg[2], mem_reg[1], mem_reg[0]};
  assign serial_w = {mem_reg[5], mem_reg[4]};
  assign fixed_w = cfg.extended_serial_select ? serial_w
    : {btn_reg, serial_w[27:0]};
  assign payload = {fixed_w, enc_w};
  // CRC takes the live flag in the bit's last slot, where the line sits low with PWM coding
  assign crc_d = (idx_reg == VLOW_IDX) ? vlow_s : payload[idx_reg[5:0]];
  assign cur_bit = (idx_reg < VLOW_IDX) ? payload[idx_reg[5:0]]
    : ((idx_reg == VLOW_IDX) ? vtx_reg : crc_reg[~idx_reg[0]]);

  // Frame sequencing, session bookkeeping and programming port
  always_comb
  begin
    launch = 1'b0;
    wr_en = 1'b0;
    sh = {data_s, psh_reg[31:1]};
    st_next = st_reg;
    te_next = tick ? 32'h0000_0000 : te_reg + 32'h0000_0001;
    hold_next = !btns[3] ? 32'h0000_0000 : (hold_ok ? hold_reg : hold_reg + 32'h0000_0001);
    pcnt_next = pcnt_reg;
    slot_next = slot_reg;
    idx_next = idx_reg;
    crc_next = crc_reg;
    vtx_next = vtx_reg;
    words_next = words_reg;
    btn_next = btn_reg;
    sync_next = sync_reg;
    psh_next = psh_reg;
    ptxt_next = ptxt_reg;
    pbits_next = pbits_reg;
    widx_next = widx_reg;
    par_next = par_reg;
    mute_next = mute_reg;
    wrap_next = wrap_reg;
    vok_next = vok_reg;
    cst_next = 1'b0;
    unique case (st_reg)
      ST_IDLE:
      begin
        te_next = 32'h0000_0000;
        words_next = 9'h000;
        if (any_btn)
          launch = 1'b1;
      end
      ST_PRE:
      begin
        if (tick)
        begin
          slot_next = slot_reg + 7'h01;
          if (slot_reg == PREAMBLE_SLOTS - 7'h01)
          begin
            st_next = ST_HDR;
            slot_next = 7'h00;
          end
        end
      end
      ST_HDR:
      begin
        if (tick)
        begin
          slot_next = slot_reg + 7'h01;
          if (slot_reg == HEADER_SLOTS - 7'h01)
          begin
            st_next = ST_DAT;
            slot_next = 7'h00;
          end
        end
      end
      ST_DAT:
      begin
        if (tick)
        begin
          slot_next = slot_reg + 7'h01;
          if (slot_reg == last_slot)
          begin
            slot_next = 7'h00;
            idx_next = idx_reg + 7'h01;
            if (idx_reg <= VLOW_IDX)
              crc_next = {crc_reg[0] ^ crc_d, crc_reg[0] ^ crc_d ^ crc_reg[1]};
            if (idx_reg == VLOW_IDX - 7'h01)
              vtx_next = vlow_s;
            if (idx_reg == LAST_IDX)
            begin
              st_next = ST_GRD;
              words_next = (words_reg == 9'h1FF) ? words_reg : words_reg + 9'h001;
            end
          end
        end
      end
      ST_GRD:
      begin
        if (tick)
        begin
          slot_next = slot_reg + 7'h01;
          if (slot_reg == GUARD_SLOTS - 7'h01)
          begin
            if (cfg.timeout_enable && words_reg >= TIMEOUT_WORDS)
              st_next = ST_OFF;
            else if (any_btn || words_reg < MIN_WORDS)
              launch = 1'b1;
            else
              st_next = ST_IDLE;
          end
        end
      end
      ST_OFF:
      begin
        if (!any_btn)
          st_next = ST_IDLE;
      end
      ST_PSH:
      begin
        if (pedge)
        begin
          psh_next = sh;
          pbits_next = pbits_reg + 8'h01;
          if (pbits_reg[4:0] == PROG_LAST_BIT)
          begin
            pbits_next = 8'h00;
            pcnt_next = 32'h0000_0000;
            if (sh[31:16] == ~sh[15:0])
            begin
              wr_en = 1'b1;
              widx_next = widx_reg + 4'h1;
              vok_next = (widx_reg == LAST_WORD);
              st_next = ST_PWR;
            end
            else
              st_next = ST_IDLE;
          end
        end
      end
      ST_PWR:
      begin
        pcnt_next = pcnt_reg + 32'h0000_0001;
        if (pcnt_reg == 32'(TWC_CYC - 1))
          st_next = ST_ACK;
      end
      ST_ACK:
      begin
        if (pedge && vok_reg)
          st_next = ST_VFY;
        else if (pedge)
        begin
          st_next = ST_PSH;
          psh_next = sh;
          pbits_next = 8'h01;
        end
      end
      ST_VFY:
      begin
        if (pedge)
        begin
          pbits_next = pbits_reg + 8'h01;
          if (pbits_reg == VERIFY_LAST_BIT)
          begin
            st_next = ST_IDLE;
            vok_next = 1'b0;
          end
        end
      end
    endcase
    // A newly pressed button restarts the word with the new function bits
    if (tx_st && new_btn)
      launch = 1'b1;
    // Entry needs button three held, then the pin raised while released by us
    if (hold_ok && data_s && data_oe_n && !(st_reg inside {ST_PSH, ST_PWR, ST_ACK, ST_VFY}))
    begin
      launch = 1'b0;
      st_next = ST_PSH;
      pbits_next = 8'h00;
      widx_next = 4'h0;
      vok_next = 1'b0;
    end
    if (launch)
    begin
      st_next = ST_PRE;
      te_next = 32'h0000_0000;
      slot_next = 7'h00;
      idx_next = 7'h00;
      crc_next = 2'h0;
      btn_next = any_btn ? btns : btn_reg;
      mute_next = cfg.long_guard_enable & par_reg;
      par_next = ~par_reg;
      sync_next = sync_reg + 16'h0001;
      wrap_next = wrap_reg | (sync_reg == 16'hFFFF);
      ptxt_next = {btn_next, cfg.user_bits, cfg.counter_wrap_flag & ~wrap_next,
        cfg.independent_counter_select, serial_w[7:0], sync_next};
      cst_next = 1'b1;
    end
    if (wr_en && widx_reg == SYNC_WORD)
      sync_next = sh[15:0];
    for (int i = 0; i < PROG_WORDS; i++)
      mem_next[i] = (wr_en && widx_reg == 4'(i)) ? sh[15:0] : mem_reg[i];
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      st_reg <= ST_IDLE;
      te_reg <= 32'h0000_0000;
      hold_reg <= 32'h0000_0000;
      pcnt_reg <= 32'h0000_0000;
      slot_reg <= 7'h00;
      idx_reg <= 7'h00;
      crc_reg <= 2'h0;
      vtx_reg <= 1'b0;
      words_reg <= 9'h000;
      btn_reg <= 4'h0;
      sync_reg <= 16'h0000;
      psh_reg <= 32'h0000_0000;
      ptxt_reg <= 32'h0000_0000;
      pbits_reg <= 8'h00;
      widx_reg <= 4'h0;
      par_reg <= 1'b0;
      mute_reg <= 1'b0;
      wrap_reg <= 1'b0;
      vok_reg <= 1'b0;
      cst_reg <= 1'b0;
      pclk_reg <= 1'b0;
      for (int i = 0; i < PROG_WORDS; i++)
        mem_reg[i] <= 16'h0000;
    end
    else
    begin
      st_reg <= st_next;
      te_reg <= te_next;
      hold_reg <= hold_next;
      pcnt_reg <= pcnt_next;
      slot_reg <= slot_next;
      idx_reg <= idx_next;
      crc_reg <= crc_next;
      vtx_reg <= vtx_next;
      words_reg <= words_next;
      btn_reg <= btn_next;
      sync_reg <= sync_next;
      psh_reg <= psh_next;
      ptxt_reg <= ptxt_next;
      pbits_reg <= pbits_next;
      widx_reg <= widx_next;
      par_reg <= par_next;
      mute_reg <= mute_next;
      wrap_reg <= wrap_next;
      vok_reg <= vok_next;
      cst_reg <= cst_next;
      pclk_reg <= pclk_s;
      mem_reg <= mem_next;
    end
  end

  logic out_reg, out_next, oe_n_reg, oe_n_next, led_n_reg, led_n_next, flash_reg, flash_next;
  logic [31:0] led_cnt_reg, led_cnt_next;

  // Pin levels follow the state one cycle later; flashing runs only while sending
  always_comb
  begin
    out_next = 1'b0;
    oe_n_next = 1'b1;
    led_n_next = 1'b1;
    flash_next = 1'b0;
    led_cnt_next = 32'h0000_0000;
    if (tx_st)
    begin
      oe_n_next = 1'b0;
      led_cnt_next = led_cnt_reg + 32'h0000_0001;
      flash_next = flash_reg;
      if (led_cnt_reg == 32'(LED_CYC - 1))
      begin
        led_cnt_next = 32'h0000_0000;
        flash_next = ~flash_reg;
      end
      led_n_next = vlow_s ? flash_reg : 1'b0;
      if (st_reg == ST_PRE)
        out_next = ~slot_reg[0];
      else if (st_reg == ST_DAT && cfg.manchester_select)
        out_next = (slot_reg == 7'h00) ? cur_bit : ~cur_bit;
      else if (st_reg == ST_DAT)
        out_next = (slot_reg == 7'h00) | ((slot_reg == 7'h01) & ~cur_bit);
      if (mute_reg)
        out_next = 1'b0;
    end
    else if (st_reg == ST_OFF)
      oe_n_next = 1'b0;
    else if (st_reg == ST_ACK || st_reg == ST_VFY)
    begin
      oe_n_next = 1'b0;
      out_next = (st_reg == ST_ACK) | mem_reg[pbits_reg[7:4]][pbits_reg[3:0]];
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      out_reg <= 1'b0;
      oe_n_reg <= 1'b1;
      led_n_reg <= 1'b1;
      flash_reg <= 1'b0;
      led_cnt_reg <= 32'h0000_0000;
    end
    else
    begin
      out_reg <= out_next;
      oe_n_reg <= oe_n_next;
      led_n_reg <= led_n_next;
      flash_reg <= flash_next;
      led_cnt_reg <= led_cnt_next;
    end
  end

  assign data_out = out_reg;
  assign data_oe_n = oe_n_reg;
  assign indicator_out_n = led_n_reg;

  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence pre_to_hdr_s;
    st_reg == ST_PRE ##1 st_reg == ST_HDR;
  endsequence

  frame_order_a: assert property (pre_to_hdr_s |-> slot_reg == 7'h00 && crc_reg == 2'h0)
    else $error("header not entered cleanly from preamble");
  word_length_a: assert property ($rose(st_reg == ST_GRD) |-> $past(idx_reg) == LAST_IDX)
    else $error("guard entered before 67 bits");
  crc_first_a: assert property ((st_reg == ST_DAT && tick && slot_reg == last_slot
    && idx_reg == 7'h00) |=> crc_reg == {2{$past(crc_d)}})
    else $error("crc first step wrong");
  extended_serial_select_field_a: assert property (!cfg.extended_serial_select |-> fixed_w[31:28] == btn_reg)
    else $error("function bits missing from fixed block");
  min_words_a: assert property ((st_reg == ST_GRD && st_next == ST_IDLE)
    |-> words_reg >= MIN_WORDS && !any_btn)
    else $error("powered down too early");
  abort_new_a: assert property ((tx_st && new_btn && st_next == ST_PRE)
    |=> st_reg == ST_PRE && idx_reg == 7'h00 && btn_reg == $past(btns))
    else $error("abort did not restart the word");
  mute_line_a: assert property ((mute_reg && tx_st) |=> !data_out)
    else $error("muted word drove the line");
  shutoff_hold_a: assert property ((st_reg == ST_OFF && any_btn)
    |=> st_reg == ST_OFF ##1 !data_out && indicator_out_n)
    else $error("shutoff left early or outputs wrong");
  guard_led_a: assert property (st_reg == ST_GRD |=> indicator_out_n)
    else $error("indicator on during guard");
  verify_once_a: assert property ((st_reg == ST_VFY && st_next == ST_IDLE)
    |=> !vok_reg ##1 st_reg != ST_VFY)
    else $error("verify allowed twice");
  cipher_ready_a: assert property (st_reg == ST_DAT |-> cdone)
    else $error("hopping word not ready at data");
endmodule : hcw_top

// ===== test/hcw_rx_model.sv
// Receiver model: slices each word into slots and decodes PWM bits.
// Assumes PWM coding, a slot of TE clock cycles, and a word start at the drive enable.
`timescale 1ns/10ps
module hcw_rx_model #(
  parameter int TE = 4
) (
  input wire logic clk,
  input wire logic data_out,
  input wire logic data_oe_n
);
  logic [233:0] slot;
  logic [66:0] bits;
  int words = 0;
  logic crc_ok = 1'b0;
  logic frame_ok = 1'b0;

  // Two-bit CRC over bits 0 to 64, starting from zero
  function automatic logic [1:0] crc_of(input logic [64:0] b);
    logic [1:0] c;
    c = 2'h0;
    for (int n = 0; n < 65; n++)
      c = {c[0] ^ b[n], c[0] ^ b[n] ^ c[1]};
    return c;
  endfunction : crc_of

  // Sample mid-slot so edge jitter of a cycle cannot flip a slot
  always
  begin
    @(negedge data_oe_n);
    repeat (TE / 2) @(posedge clk);
    for (int s = 0; s < 234; s++)
    begin
      slot[s] = data_out;
      repeat (TE) @(posedge clk);
    end
    for (int i = 0; i < 67; i++)
      bits[i] = ~slot[34 + 3 * i];
    // A failed check is retried with the battery bit flipped
    crc_ok = (crc_of(bits[64:0]) == bits[66:65]) ||
             (crc_of(bits[64:0] ^ {1'b1, 64'h0}) == bits[66:65]);
    frame_ok = 1'b1;
    for (int s = 0; s < 33; s++)
      if (slot[s] != (s < 23 && s % 2 == 0))
        frame_ok = 1'b0;
    for (int i = 0; i < 67; i++)
      if (slot[33 + 3 * i] != 1'b1 || slot[35 + 3 * i] != 1'b0)
        frame_ok = 1'b0;
    words++;
  end
endmodule : hcw_rx_model

// ===== test/testbench.sv
// Self-checking bench for the transmitter: table of short presses, awkward cases, programming.
// Assumes shortened timing parameters and a blank memory, so the serial number is zero.
`timescale 1ns/10ps
module testbench;
  import hcw_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  hcw_cfg_t cfg = '0;
  logic [3:0] btn = 4'h0;
  logic vlow = 1'b0;
  logic pin_in = 1'b0;
  logic [15:0] pw;
  logic [31:0] ser;
  logic data_out;
  logic data_oe_n;
  logic indicator_out_n;
  int fails = 0;
  int total_checks = 0;
  int cyc = 0;
  int w0;
  // Row: extended serial, low supply, buttons
  logic [5:0] rows [4] = '{6'h01, 6'h18, 6'h2F, 6'h35};

  hcw_top #(.TE_CYC(4), .HOLD_CYC(10), .TWC_CYC(8), .LED_CYC(16)) hcw_top_inst (
    .clk(clk), .nrst(nrst), .cfg(cfg), .button_zero_in(btn[0]), .button_one_in(btn[1]),
    .button_two_in(btn[2]), .button_three_in(btn[3]), .vlow_in(vlow), .data_in(pin_in),
    .data_out(data_out), .data_oe_n(data_oe_n), .indicator_out_n(indicator_out_n));
  hcw_rx_model #(.TE(4)) hcw_rx_model_inst (
    .clk(clk), .data_out(data_out), .data_oe_n(data_oe_n));

  always #2.5 clk = ~clk;

  task automatic check_bits(input string what, input logic [35:0] exp, input logic [35:0] got);
    total_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : check_bits

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : report_and_stop

  // Programmed image: distinct words so a swapped index shows in readback
  function automatic logic [15:0] pword(input int i);
    return 16'(16'h3C5B + 16'(i * 16'h1111));
  endfunction : pword

  // One clock on button three; data goes out while the clock is low, well before the rise
  task automatic prog_clk(input logic bit_in);
    btn[3] <= 1'b0;
    pin_in <= bit_in;
    repeat (3) @(posedge clk);
    btn[3] <= 1'b1;
    repeat (3) @(posedge clk);
  endtask : prog_clk

  // Bounded waits: a word and its guard take 1136 cycles, well under the 3000-cycle wait
  task automatic wait_oe(input logic lvl);
    for (int i = 0; i < 3000 && data_oe_n !== lvl; i++)
      @(posedge clk);
  endtask : wait_oe

  task automatic wait_words(input int n);
    for (int i = 0; i < 6000 && hcw_rx_model_inst.words < w0 + n; i++)
      @(posedge clk);
    repeat (1500) @(posedge clk);
    check_bits("words", 36'(n), 36'(hcw_rx_model_inst.words - w0));
  endtask : wait_words

  // Hang guard
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      fails++;
      report_and_stop();
    end
  end

  initial
  begin
    repeat (5) @(posedge clk);
    check_bits("reset pins", 36'h3, 36'({data_out, data_oe_n, indicator_out_n}));
    nrst <= 1'b1;
    foreach (rows[r])
    begin
      cfg.extended_serial_select <= rows[r][5];
      vlow <= rows[r][4];
      w0 = hcw_rx_model_inst.words;
      repeat (4) @(posedge clk);
      btn <= rows[r][3:0];
      wait_oe(1'b0);
      btn <= 4'h0; // released early, word must still finish
      repeat (4) @(posedge clk);
      check_bits("lit", 36'h0, 36'(indicator_out_n));
      repeat (16) @(posedge clk);
      check_bits("flash", 36'(rows[r][4]), 36'(indicator_out_n));
      wait_oe(1'b1);
      repeat (2) @(posedge clk);
      check_bits("guard", 36'h1, 36'(indicator_out_n));
      wait_words(2);
      check_bits("fixed", 36'({2'h3, rows[r][4], rows[r][5] ? 32'h0 : {rows[r][3:0], 28'h0}}),
        36'({hcw_rx_model_inst.frame_ok, hcw_rx_model_inst.crc_ok,
        hcw_rx_model_inst.bits[64:32]}));
    end
    // A second button during the preamble restarts with the new code
    cfg.extended_serial_select <= 1'b0;
    vlow <= 1'b0;
    w0 = hcw_rx_model_inst.words;
    btn <= 4'h1;
    wait_oe(1'b0);
    repeat (6) @(posedge clk);
    btn <= 4'h3;
    repeat (8) @(posedge clk);
    btn <= 4'h0;
    wait_words(2);
    check_bits("restart", 36'h13, 36'({hcw_rx_model_inst.crc_ok,
      hcw_rx_model_inst.bits[63:60]}));
    // Programming: button three held, button one at the first key bit, then the pin raised
    pw = pword(0);
    btn <= {1'b1, 1'b0, pw[0], 1'b0};
    repeat (20) @(posedge clk);
    pin_in <= 1'b1;
    // The press also sends a word; entry is taken once the pin is released in the guard
    wait_oe(1'b1);
    repeat (10) @(posedge clk);
    for (int w = 0; w < 12; w++)
    begin
      pw = pword(w);
      for (int b = 0; b < 32; b++)
        prog_clk(b < 16 ? pw[b] : ~pw[b - 16]);
      repeat (12) @(posedge clk);
      check_bits("ack", 36'h2, 36'({data_out, data_oe_n}));
    end
    // Readback: one clock enters it, then each bit stands until its clock
    prog_clk(1'b0);
    for (int k = 0; k < 192; k++)
    begin
      pw = pword(k / 16);
      repeat (2) @(posedge clk);
      check_bits("readback", 36'(pw[k % 16]), 36'(data_out));
      prog_clk(1'b0);
    end
    // Buttons still held after readback start a session with the programmed serial
    w0 = hcw_rx_model_inst.words;
    btn <= 4'h0;
    wait_words(2);
    ser = {pword(5), pword(4)};
    check_bits("serial", 36'({2'h3, 1'b0, 4'hA, ser[27:0]}),
      36'({hcw_rx_model_inst.frame_ok, hcw_rx_model_inst.crc_ok,
      hcw_rx_model_inst.bits[64:32]}));
    report_and_stop();
  end
endmodule : testbench
